/* hdl/spe_event_id.sv */
// Purpose: interrupt enable and event identification for an enhanced serial port
// Assumes: event inputs come from serial port logic on CLK; host access over APB
// Notes:   data path, queues and line format live elsewhere; this block only flags
// What this block does
// (RULE1) enable bit 5 allows interrupt when transmitter and its queue drain
// (RULE2) remote-control infrared: enable bit 2 covers line status and transmit underrun
// (RULE3) remote-control infrared: other enable bits behave as in extended modes
// (RULE4) offset shared: reads give event register, writes go to queue control
// (RULE5) non-extended view ranks pending sources into four levels, reports top one
// (RULE6) non-extended bit 0 reads 0 while an enabled source pends, resets 1
// (RULE7) non-extended bits 2,1 give priority code of top source, reset 00
// (RULE8) bit 3 reads 1 only for top-ranked receive timeout with queues on
// (RULE9) bits 7,6 show queue enable, bits 5,4 read 0
// (RULE10) code 0001 nothing pending; 0110 line error, cleared by line state read
// (RULE11) code 0100 receive data high, clears on data read or level drop
// (RULE12) code 1100 receive timeout, cleared by receive data read
// (RULE13) code 0010 transmit low, cleared by event read as top or data write
// (RULE14) code 0000 modem change, cleared by modem state read
// (RULE15) extended view: one flag per source, set regardless of enables
// (RULE16) terminal count flag clears on event read; others on own register read
// (RULE17) extended bit 0: receive holding full, or queue high or timed out
// (RULE18) extended bit 1: transmit holding empty, or queue below threshold
// (RULE19) extended bit 2 flags receive errors or break in serial modes
// (RULE20) remote-control infrared: bit 2 flags receive overrun or transmit underrun
// (RULE21) serial mode: bit 3 set while any modem change bit is set
// (RULE22) infrared modes: bit 3 is modem event, forced 0 when select set
// (RULE23) enable bit 4 allows terminal count interrupt while DMA is enabled
// (RULE24) extended bit 5 mirrors transmitter drained status
// (RULE25) extended view: interrupt when any flag meets its set enable bit
// (RULE26) reserved bits read 0 and reserved enables have no effect
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module spe_event_id
    import spe_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        RX_DATA_HIGH,
    input  wire logic        RX_TIMEOUT,
    input  wire logic        TX_DATA_LOW,
    input  wire logic        LINE_ERROR,
    input  wire logic        RX_OVERRUN,
    input  wire logic        TX_UNDERRUN,
    input  wire logic [3:0]  MODEM_CHANGE,
    input  wire logic        TX_DRAINED,
    input  wire logic        DMA_TERMINAL,
    output logic             IRQ
);

    // true in any infrared mode; used by the modem event decode and its check
    function automatic logic spe_is_ir(input spe_mode_t m);
        spe_is_ir = (m != SPE_MODE_UART);
    endfunction

    logic        rst_meta_reg;
    logic        rst_n_reg;
    logic        ready_reg;
    logic [31:0] rdata_reg;
    logic        slverr_reg;
    logic        irq_reg;
    logic [7:0]  ier_reg;
    logic [7:0]  ctrl_reg;
    logic        queue_en_reg;
    logic        line_flag_reg;
    logic        rto_flag_reg;
    logic        txlow_flag_reg;
    logic        txlow_seen_reg;
    logic [3:0]  modem_reg;
    logic        tc_flag_reg;
    logic [3:0]  rd_code_reg;

    logic        extended_select;
    spe_mode_t   mode;
    logic        fen;
    logic        access;
    logic        done;
    logic        done_rd;
    logic        done_wr;
    logic [9:0]  idx;
    logic        mapped;
    logic [7:0]  ier_mask;
    logic        modem_event;
    logic        line_set;
    logic [5:0]  ext_flags;
    logic [7:0]  eir_base;
    logic [7:0]  eir_ext;
    logic [7:0]  eir_value;
    logic [7:0]  rd_byte;
    logic        pend_any;

    // release the reset through two flops so all state leaves reset on one edge
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // bus decode; one wait state keeps PRDATA and PREADY straight from flops
    assign access  = PSEL & PENABLE & ~ready_reg;
    assign done    = PSEL & PENABLE & ready_reg;
    assign done_rd = done & ~PWRITE & ~slverr_reg;
    assign done_wr = done & PWRITE & ~slverr_reg;
    assign idx     = PADDR[11:2];
    assign mapped  = (idx == SPE_IDX_DATA) | (idx == SPE_IDX_ENABLE) | (idx == SPE_IDX_EVENT) |
                     (idx == SPE_IDX_LINE) | (idx == SPE_IDX_MODEM) | (idx == SPE_IDX_CTRL);

    // mode decode from own control register
    assign extended_select = ctrl_reg[SPE_CTRL_EXT];
    assign mode            = spe_mode_t'(ctrl_reg[SPE_CTRL_MODE_HI:SPE_CTRL_MODE_LO]);
    assign fen             = queue_en_reg | (mode == SPE_MODE_RCIR);  // remote-control mode always queues
    assign ier_mask        = extended_select ? SPE_IER_MASK_EXT : SPE_IER_MASK_BASE;  // [RULE26]

    // link-status source differs in remote-control infrared mode
    assign line_set = (mode == SPE_MODE_RCIR) ? (RX_OVERRUN | TX_UNDERRUN) : LINE_ERROR;  // [RULE2] [RULE19] [RULE20]
    assign modem_event = (|modem_reg) &
                         ~(spe_is_ir(mode) & ctrl_reg[SPE_CTRL_INFRARED_MODEM_STATUS_SELECT]);  // [RULE21] [RULE22]

    // extended view flags, independent of enables
    assign ext_flags = {TX_DRAINED,                           // [RULE24]
                        tc_flag_reg,                          // [RULE16]
                        modem_event,                          // [RULE21]
                        line_flag_reg,                        // [RULE19]
                        txlow_flag_reg,                       // [RULE18]
                        RX_DATA_HIGH | (fen & rto_flag_reg)}; // [RULE15] [RULE17]
    assign eir_ext   = {2'b00, ext_flags};                    // [RULE26]

    // non-extended priority encoder, highest source first
    always_comb begin
        eir_base = {fen, fen, 2'b00, SPE_CODE_NONE};  // [RULE9] [RULE10]
        if (ier_reg[SPE_EN_LINE] & line_flag_reg) begin
            eir_base[3:0] = SPE_CODE_LINE;  // [RULE5] [RULE7] [RULE10]
        end else if (ier_reg[SPE_EN_RX] & RX_DATA_HIGH) begin
            eir_base[3:0] = SPE_CODE_RXHIGH;  // [RULE11]
        end else if (ier_reg[SPE_EN_RX] & fen & rto_flag_reg) begin
            eir_base[3:0] = SPE_CODE_RXTIMEOUT;  // [RULE8] [RULE12]
        end else if (ier_reg[SPE_EN_TX] & txlow_flag_reg) begin
            eir_base[3:0] = SPE_CODE_TXLOW;  // [RULE13]
        end else if (ier_reg[SPE_EN_MODEM] & modem_event) begin
            eir_base[3:0] = SPE_CODE_MODEM;  // [RULE14]
        end
    end

    assign eir_value = extended_select ? eir_ext : eir_base;  // [RULE5] [RULE15]

    // interrupt decision; terminal count needs DMA enabled as well
    always_comb begin
        if (extended_select) begin
            pend_any = |(ext_flags & ier_reg[5:0] &
                         {1'b1, ctrl_reg[SPE_CTRL_DMA], 4'hf});  // [RULE1] [RULE23] [RULE25]
        end else begin
            pend_any = ~eir_base[0];  // [RULE6]
        end
    end

    // read mux; the event index always reads the event view
    always_comb begin
        rd_byte = 8'h00;
        if (idx == SPE_IDX_ENABLE) begin
            rd_byte = ier_reg;
        end else if (idx == SPE_IDX_EVENT) begin
            rd_byte = eir_value;  // [RULE4]
        end else if (idx == SPE_IDX_LINE) begin
            rd_byte = {1'b0, TX_DRAINED, 5'h00, line_flag_reg};
        end else if (idx == SPE_IDX_MODEM) begin
            rd_byte = {4'h0, modem_reg};
        end else if (idx == SPE_IDX_CTRL) begin
            rd_byte = ctrl_reg;
        end
    end

    // bus answer: ready one cycle after the access phase starts
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ready_reg   <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            slverr_reg  <= 1'b0;
            rd_code_reg <= SPE_CODE_NONE;
        end else begin
            ready_reg   <= access;
            slverr_reg  <= access & ~mapped;
            if (access & ~PWRITE) begin
                rdata_reg   <= {24'h00_0000, rd_byte};
                rd_code_reg <= extended_select ? SPE_CODE_NONE : eir_value[3:0];
            end
        end
    end

    // enable register; extended-only bits drop when leaving extended view
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ier_reg <= SPE_IER_RESET;  // [RULE1] [RULE2] [RULE23]
        end else if (done_wr & (idx == SPE_IDX_ENABLE)) begin
            ier_reg <= PWDATA[7:0] & ier_mask;  // [RULE3] [RULE26]
        end else begin
            ier_reg <= ier_reg & ier_mask;
        end
    end

    // control register and queue enable (write side of the shared offset)
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ctrl_reg     <= SPE_CTRL_RESET;
            queue_en_reg <= 1'b0;
        end else begin
            if (done_wr & (idx == SPE_IDX_CTRL)) begin
                ctrl_reg <= PWDATA[7:0] & SPE_CTRL_MASK;
            end
            if (done_wr & (idx == SPE_IDX_EVENT)) begin
                queue_en_reg <= PWDATA[SPE_FCR_QUEUE_EN];  // [RULE4]
            end
        end
    end

    // line flag: set wins over the clear from a line state read
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            line_flag_reg <= 1'b0;
        end else if (line_set) begin
            line_flag_reg <= 1'b1;  // [RULE19] [RULE20]
        end else if (done_rd & (idx == SPE_IDX_LINE)) begin
            line_flag_reg <= 1'b0;  // [RULE10] [RULE16]
        end
    end

    // receive timeout flag cleared by receive data read
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rto_flag_reg <= 1'b0;
        end else if (RX_TIMEOUT & fen) begin
            rto_flag_reg <= 1'b1;
        end else if (done_rd & (idx == SPE_IDX_DATA)) begin
            rto_flag_reg <= 1'b0;  // [RULE12]
        end
    end

    // transmit low flag: set on the rising level so a clear is not undone at once
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            txlow_seen_reg <= 1'b0;
            txlow_flag_reg <= 1'b0;
        end else begin
            txlow_seen_reg <= TX_DATA_LOW;
            if (TX_DATA_LOW & ~txlow_seen_reg) begin
                txlow_flag_reg <= 1'b1;  // [RULE18]
            end else if (done_wr & (idx == SPE_IDX_DATA)) begin
                txlow_flag_reg <= 1'b0;  // [RULE13]
            end else if (done_rd & (idx == SPE_IDX_EVENT) & (rd_code_reg == SPE_CODE_TXLOW)) begin
                txlow_flag_reg <= 1'b0;  // [RULE13]
            end
        end
    end

    // modem change bits; each new change wins over the read clear
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            modem_reg <= 4'h0;
        end else if (done_rd & (idx == SPE_IDX_MODEM)) begin
            modem_reg <= MODEM_CHANGE;  // [RULE14]
        end else begin
            modem_reg <= modem_reg | MODEM_CHANGE;
        end
    end

    // terminal count flag cleared by reading the event view
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tc_flag_reg <= 1'b0;
        end else if (DMA_TERMINAL) begin
            tc_flag_reg <= 1'b1;
        end else if (done_rd & (idx == SPE_IDX_EVENT)) begin
            tc_flag_reg <= 1'b0;  // [RULE16]
        end
    end

    // registered interrupt output, one cycle behind its cause
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= pend_any;  // [RULE25]
        end
    end

    assign PRDATA  = rdata_reg;
    assign PREADY  = ready_reg;
    assign PSLVERR = slverr_reg;
    assign IRQ     = irq_reg;

    // checks on the block's own behaviour
    default clocking spe_cb @(posedge CLK);
    endclocking
    default disable iff (!rst_n_reg);

    chk_ext_irq_follow: assert property (extended_select & |(ext_flags & ier_reg[5:0] & 6'h2f)
        |=> IRQ) else $error("extended irq missing");  // [RULE25]
    chk_idle_no_irq: assert property (!extended_select & eir_base[0] |=> !IRQ)
        else $error("irq with nothing pending");  // [RULE6]
    chk_line_top: assert property (!extended_select & ier_reg[SPE_EN_LINE] & line_flag_reg
        |-> eir_value[3:0] == SPE_CODE_LINE) else $error("line source not top");  // [RULE10]
    chk_fen_bits: assert property (!extended_select |-> eir_value[7:4] == {fen, fen, 2'b00})
        else $error("queue bits wrong");  // [RULE9]
    chk_timeout_bit: assert property (!extended_select & eir_value[3] |-> fen & rto_flag_reg)
        else $error("timeout bit without cause");  // [RULE8]
    chk_line_sticky: assert property (line_set ##1 !(done_rd & idx == SPE_IDX_LINE)[*2]
        |-> line_flag_reg) else $error("line flag lost");  // [RULE19]
    chk_tc_clear: assert property (done_rd & idx == SPE_IDX_EVENT & !DMA_TERMINAL
        |=> !tc_flag_reg) else $error("terminal count not cleared");  // [RULE16]
    // extended-only bits drop one edge after the view leaves extended, so look at the previous view
    chk_ier_reserved: assert property (ier_reg[7:6] == 2'b00 && ($past(extended_select) || ier_reg[5:4] == 2'b00))
        else $error("reserved enable bit set");  // [RULE26]
    chk_ms_forced: assert property (spe_is_ir(mode) & ctrl_reg[SPE_CTRL_INFRARED_MODEM_STATUS_SELECT] |-> !eir_ext[3])
        else $error("modem event not forced");  // [RULE22]
    chk_ready_wait: assert property (PSEL & PENABLE & !PREADY |=> PREADY)
        else $error("bus answer late");  // [RULE4]

    cov_ext_irq: cover property (extended_select ##1 IRQ);
    cov_txlow_clear: cover property (txlow_flag_reg ##1 !txlow_flag_reg);
    cov_timeout_code: cover property (eir_value[3:0] == SPE_CODE_RXTIMEOUT);
    cov_unmapped: cover property (PSLVERR & PREADY);

endmodule

/* hdl/spe_pkg.sv */
// Purpose: shared constants for the serial port event identification block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   register indexes are word indexes; byte address is four times the index
package spe_pkg;

    // word indexes on the register bus (byte address = index * 4)
    localparam logic [9:0] SPE_IDX_DATA   = 10'h000;
    localparam logic [9:0] SPE_IDX_ENABLE = 10'h001;
    localparam logic [9:0] SPE_IDX_EVENT  = 10'h002;  // read: event_identification, write: queue_control
    localparam logic [9:0] SPE_IDX_LINE   = 10'h005;
    localparam logic [9:0] SPE_IDX_MODEM  = 10'h006;
    localparam logic [9:0] SPE_IDX_CTRL   = 10'h008;

    // operating modes, gray coded
    typedef enum logic [1:0] {
        SPE_MODE_UART  = 2'b00,
        SPE_MODE_SRIR  = 2'b01,
        SPE_MODE_ASKIR = 2'b11,
        SPE_MODE_RCIR  = 2'b10
    } spe_mode_t;

    // interrupt_enable bit positions
    localparam int SPE_EN_RX      = 0;
    localparam int SPE_EN_TX      = 1;
    localparam int SPE_EN_LINE    = 2;
    localparam int SPE_EN_MODEM   = 3;
    localparam int SPE_EN_TC      = 4;
    localparam int SPE_EN_DRAINED = 5;

    // writable enable bits per view; bits 7,6 always reserved
    localparam logic [7:0] SPE_IER_MASK_BASE = 8'h0f;
    localparam logic [7:0] SPE_IER_MASK_EXT  = 8'h3f;
    localparam logic [7:0] SPE_IER_RESET     = 8'h00;

    // encoded sources in the non-extended view (bits 3..0)
    localparam logic [3:0] SPE_CODE_NONE      = 4'h1;
    localparam logic [3:0] SPE_CODE_LINE      = 4'h6;
    localparam logic [3:0] SPE_CODE_RXHIGH    = 4'h4;
    localparam logic [3:0] SPE_CODE_RXTIMEOUT = 4'hc;
    localparam logic [3:0] SPE_CODE_TXLOW     = 4'h2;
    localparam logic [3:0] SPE_CODE_MODEM     = 4'h0;
    localparam logic [7:0] SPE_EIR_RESET      = 8'h01;

    // own control register fields
    localparam int SPE_CTRL_EXT     = 0;
    localparam int SPE_CTRL_MODE_LO = 1;
    localparam int SPE_CTRL_MODE_HI = 2;
    localparam int SPE_CTRL_INFRARED_MODEM_STATUS_SELECT  = 3;
    localparam int SPE_CTRL_DMA     = 4;
    localparam logic [7:0] SPE_CTRL_MASK  = 8'h1f;
    localparam logic [7:0] SPE_CTRL_RESET = 8'h00;

    // queue_control enable bit and line state drained bit
    localparam int SPE_FCR_QUEUE_EN = 0;
    localparam int SPE_LSR_DRAINED  = 6;

endpackage

/* dv/spe_host.sv */
// Purpose: host processor model that reaches the event block over APB
// Assumes: one transfer at a time; the slave answers with PREADY
// Notes:   every wait is bounded; a transfer that never completes returns ok low
`timescale 1ns/1ps
module spe_host (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // bus idle from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // setup, then access held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        ok  = 1'b0;
        rd  = 32'h0000_0000;
        err = 1'b0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                ok  = 1'b1;
                rd  = prdata;
                err = pslverr;
            end
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~wd;  // released data does not keep its last value
    endtask
endmodule

/* dv/serial_port_event_identification_bench.sv */
// Purpose: self-checking bench for the enable and event identification block
// Assumes: host model speaks APB; event inputs driven on rising edges
// Notes:   expectations follow the priority codes and extended flag layout
`timescale 1ns/1ps
module serial_port_event_identification_bench
    import spe_pkg::*;
();
    logic        clk;
    logic        resetn;
    wire         psel;
    wire         penable;
    wire         pwrite;
    wire  [11:0] paddr;
    wire  [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [8:0]  pv;   // {tc, underrun, overrun, line, timeout, modem[3:0]}
    logic        rxh;
    logic        txl;
    logic        drn;
    int          n_mismatch;
    int          n_compared;

    spe_event_id spe_event_id_i (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RX_DATA_HIGH(rxh), .RX_TIMEOUT(pv[4]), .TX_DATA_LOW(txl), .LINE_ERROR(pv[5]),
        .RX_OVERRUN(pv[6]), .TX_UNDERRUN(pv[7]), .MODEM_CHANGE(pv[3:0]), .TX_DRAINED(drn),
        .DMA_TERMINAL(pv[8]), .IRQ(irq)
    );

    spe_host spe_host_i (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    // free running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    // one bus transfer; a hung bus ends the run at once
    task automatic acc(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        logic ok;
        spe_host_i.xfer(wr, idx, wd, rd, err, ok);
        if (ok !== 1'b1) begin
            $display("BAD bus_done expected 1 seen %b", ok);
            n_mismatch++;
            summarize();
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] v);
        logic [31:0] d;
        logic        e;
        acc(1'b1, idx, {24'h000000, v}, d, e);
    endtask

    task automatic rchk(input string what, input logic [9:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic        e;
        acc(1'b0, idx, 32'h0000_0000, d, e);
        chk(what, {24'h000000, exp}, d);
        chk("pslverr", 32'h0000_0000, {31'h0, e});
    endtask

    task automatic pulse(input logic [8:0] p);
        @(posedge clk);
        pv <= p;
        @(posedge clk);
        pv <= 9'h000;
    endtask

    task automatic lvl(input logic [2:0] l);  // {drained, tx low, rx high}
        @(posedge clk);
        {drn, txl, rxh} <= l;
    endtask

    // irq lags its cause by one cycle; look after it has settled
    task automatic ichk(input logic exp);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic        e;
        rchk("event", SPE_IDX_EVENT, 8'h01);    // reset value
        rchk("enable", SPE_IDX_ENABLE, 8'h00);  // reset value
        acc(1'b0, 10'h3ff, 32'h0000_0000, d, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, d);         // reserved place reads 0
        $display("test reset done");
    endtask

    task automatic t_ranked();
        wr(SPE_IDX_ENABLE, 8'hff);
        rchk("enable", SPE_IDX_ENABLE, 8'h0f);  // upper bits held off
        pulse(9'h010);
        rchk("event", SPE_IDX_EVENT, 8'h01);    // timeout ignored, queues off
        pulse(9'h001);
        rchk("event", SPE_IDX_EVENT, 8'h00);    // modem code, no queue bits
        wr(SPE_IDX_EVENT, 8'h01);
        rchk("event", SPE_IDX_EVENT, 8'hc0);    // write went to queue control
        lvl(3'b010);
        rchk("event", SPE_IDX_EVENT, 8'hc2);    // tx low outranks modem
        rchk("event", SPE_IDX_EVENT, 8'hc0);    // event read as top cleared tx low
        pulse(9'h010);
        rchk("event", SPE_IDX_EVENT, 8'hcc);    // timeout on top
        lvl(3'b011);
        rchk("event", SPE_IDX_EVENT, 8'hc4);    // rx high on top
        pulse(9'h020);
        rchk("event", SPE_IDX_EVENT, 8'hc6);    // line error highest
        rchk("line", SPE_IDX_LINE, 8'h01);      // line read clears
        rchk("event", SPE_IDX_EVENT, 8'hc4);    // back to rx high
        lvl(3'b010);
        rchk("event", SPE_IDX_EVENT, 8'hcc);    // level drop clears
        rchk("data", SPE_IDX_DATA, 8'h00);
        rchk("event", SPE_IDX_EVENT, 8'hc0);    // data read cleared timeout
        rchk("modem", SPE_IDX_MODEM, 8'h01);
        rchk("event", SPE_IDX_EVENT, 8'hc1);    // modem read clears, none pending
        lvl(3'b000);
        wr(SPE_IDX_EVENT, 8'h00);
        $display("test ranked done");
    endtask

    task automatic t_extended();
        wr(SPE_IDX_CTRL, 8'h01);
        wr(SPE_IDX_ENABLE, 8'h00);
        pulse(9'h020);
        rchk("event", SPE_IDX_EVENT, 8'h04);    // flag set with enable off
        ichk(1'b0);                             // no enable, no request
        wr(SPE_IDX_ENABLE, 8'h04);
        ichk(1'b1);                             // flag meets enable
        rchk("line", SPE_IDX_LINE, 8'h01);
        rchk("event", SPE_IDX_EVENT, 8'h00);    // own register read clears
        lvl(3'b100);
        rchk("event", SPE_IDX_EVENT, 8'h20);    // drained mirror
        wr(SPE_IDX_ENABLE, 8'h20);
        ichk(1'b1);                             // drained request
        lvl(3'b000);
        ichk(1'b0);                             // drained gone
        pulse(9'h100);
        rchk("event", SPE_IDX_EVENT, 8'h10);    // terminal count flag
        rchk("event", SPE_IDX_EVENT, 8'h00);    // cleared by event read
        wr(SPE_IDX_ENABLE, 8'h10);
        pulse(9'h100);
        ichk(1'b0);                             // dma off blocks it
        wr(SPE_IDX_CTRL, 8'h11);
        ichk(1'b1);                             // dma on lets it through
        rchk("event", SPE_IDX_EVENT, 8'h10);
        ichk(1'b0);                             // read dropped the flag
        lvl(3'b001);
        rchk("event", SPE_IDX_EVENT, 8'h01);    // rx high flag
        lvl(3'b010);
        rchk("event", SPE_IDX_EVENT, 8'h02);    // tx low flag
        wr(SPE_IDX_DATA, 8'h55);
        rchk("event", SPE_IDX_EVENT, 8'h00);    // data write clears, level kept
        lvl(3'b000);
        pulse(9'h004);
        rchk("event", SPE_IDX_EVENT, 8'h08);    // modem flag in serial mode
        wr(SPE_IDX_CTRL, 8'h0b);
        rchk("event", SPE_IDX_EVENT, 8'h00);    // forced off by select
        wr(SPE_IDX_CTRL, 8'h03);
        rchk("event", SPE_IDX_EVENT, 8'h08);    // infrared with select off
        rchk("modem", SPE_IDX_MODEM, 8'h04);
        rchk("event", SPE_IDX_EVENT, 8'h00);    // modem read clears
        $display("test extended done");
    endtask

    task automatic t_remote();
        wr(SPE_IDX_CTRL, 8'h05);
        wr(SPE_IDX_ENABLE, 8'h3f);
        rchk("enable", SPE_IDX_ENABLE, 8'h3f);  // same bits as extended
        wr(SPE_IDX_ENABLE, 8'h04);
        pulse(9'h040);
        rchk("event", SPE_IDX_EVENT, 8'h04);    // receive overrun
        ichk(1'b1);                             // line enable covers it
        rchk("line", SPE_IDX_LINE, 8'h01);
        pulse(9'h080);
        rchk("event", SPE_IDX_EVENT, 8'h04);    // transmit underrun
        ichk(1'b1);                             // underrun enabled too
        rchk("line", SPE_IDX_LINE, 8'h01);
        ichk(1'b0);                             // cleared by line read
        $display("test remote done");
    endtask

    // reset held for ten cycles, then the scenarios in turn
    initial begin
        resetn     = 1'b0;
        pv         = 9'h000;
        rxh        = 1'b0;
        txl        = 1'b0;
        drn        = 1'b0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_ranked();
        t_extended();
        t_remote();
        summarize();
    end
endmodule
